/* File: bench/rstk_sensor_model.sv */
// model of three digital rotor sensors
`timescale 1ns/1ps
`default_nettype none
module rstk_sensor_model (
   input wire logic core_clk_in,
   input wire logic step_in,
   input wire logic dir_in,
   input wire logic [1:0] bad_in,
   output logic a_out,
   output logic b_out,
   output logic c_out
);
   localparam logic [2:0] SEQ [0:5] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
   logic [2:0] idx = 3'h0;
   always @(posedge core_clk_in) begin
      if (step_in) begin
         idx <= dir_in ? (idx == 3'h5 ? 3'h0 : idx + 3'h1) : (idx == 3'h0 ? 3'h5 : idx - 3'h1);
      end
   end
   // all ones or zeros on demand
   assign {c_out, b_out, a_out} = bad_in[1] ? {3{bad_in[0]}} : SEQ[idx];
endmodule // rstk_sensor_model
`default_nettype wire

/* File: bench/rstk_tracker_asserts.sv */
// checker: port-level properties of the rotor sensor tracker
`timescale 1ns/1ps
`default_nettype none
module rstk_chk
   import rstk_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic rstn_in,
   input wire logic [7:0] addr_in,
   input wire logic [31:0] wr_data_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic [31:0] rd_data_out,
   input wire logic pwm_tick_in,
   input wire logic [15:0] rotor_angle_out,
   input wire logic [15:0] fault_word_out
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!rstn_in);
   sequence s_rd(logic [7:0] a);
      rd_in && addr_in == a;
   endsequence
   property p_keep(int b);
      $fell(fault_word_out[b]) |-> $past(wr_in && addr_in == ADDR_FAULT && wr_data_in[b], 2);
   endproperty
   AST_RST_ZERO: assert property (disable iff (1'b0) !rstn_in |=> rotor_angle_out == 16'h0 &&
      fault_word_out == 16'h0 && rd_data_out == 32'h0) else $error("outputs not clear");
   AST_RD_IDLE: assert property (!rd_in || addr_in > ADDR_STATUS |=> rd_data_out == 32'h0)
      else $error("read data not zero");
   AST_RD_FAULT: assert property (s_rd(ADDR_FAULT) |=> rd_data_out[15:0] == fault_word_out)
      else $error("fault read mismatch");
   AST_ANGLE_TICK: assert property ($changed(rotor_angle_out) |-> $past(pwm_tick_in))
      else $error("angle moved without tick");
   AST_INV_TICK: assert property ($rose(fault_word_out[15]) |-> $past(pwm_tick_in, 2))
      else $error("invalid fault off tick");
   AST_INV_KEEP: assert property (p_keep(FAULT_INVALID_BIT))
      else $error("invalid fault lost");
   AST_TO_ZF: assert property ($rose(fault_word_out[1]) |-> fault_word_out[0])
      else $error("timeout without zero speed");
   AST_TO_KEEP: assert property (p_keep(FAULT_TIMEOUT_BIT))
      else $error("timeout fault lost");
endmodule // rstk_chk
bind rstk_tracker rstk_chk u_chk (.core_clk_in, .rstn_in, .addr_in, .wr_data_in, .wr_in, .rd_in,
   .rd_data_out, .pwm_tick_in, .rotor_angle_out, .fault_word_out);
`default_nettype wire

/* File: bench/tb_rotor_sensor_tracker.sv */
// self-checking bench for the rotor sensor tracker
`timescale 1ns/1ps
`default_nettype none
module tb_rotor_sensor_tracker;
   import rstk_pkg::*;
   logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, tick = 1'b0, step = 1'b0, dir = 1'b1;
   logic sa, sb, sc;
   logic [1:0] bad = 2'h0;
   logic [2:0] tcnt = 3'h0;
   logic [7:0] addr = 8'h0;
   logic [31:0] wdat = 32'h0, rdat, q;
   logic [15:0] ang, flt, spd = 16'h0, flx = 16'h1234;
   logic [7:0] ra [0:6] = '{ADDR_CONFIG, ADDR_TRIM, ADDR_SILENCE, ADDR_SPAN, ADDR_UP, ADDR_DOWN,
      8'h40};
   logic [15:0] rv [0:6] = '{RESET_CONFIG, RESET_TRIM, RESET_SILENCE, RESET_SPAN, RESET_UP,
      RESET_DOWN, 16'h0};
   int error_cnt = 0, check_count = 0, cyc = 0;
   rstk_tracker #(.SILENCE_UNIT(20)) DUT (.core_clk_in(clk), .rstn_in(rstn), .addr_in(addr),
      .wr_data_in(wdat), .wr_in(wr), .rd_in(rd), .rd_data_out(rdat), .pwm_tick_in(tick),
      .sensor_input_a_in(sa), .sensor_input_b_in(sb), .sensor_input_c_in(sc),
      .analog_pair1_pos_in(12'h0), .analog_pair1_neg_in(12'h0), .analog_pair2_pos_in(12'h0),
      .analog_pair2_neg_in(12'h0), .flux_angle_in(flx), .motor_speed_in(spd),
      .rotor_angle_out(ang), .fault_word_out(flt));
   rstk_sensor_model u_hall (.core_clk_in(clk), .step_in(step), .dir_in(dir), .bad_in(bad),
      .a_out(sa), .b_out(sb), .c_out(sc));
   initial forever #20 clk = ~clk;
   // pwm tick every 8 cycles, run ceiling
   always @(posedge clk) begin
      tcnt <= tcnt + 3'h1;
      tick <= tcnt == 3'h7;
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         error_cnt++;
         report_and_stop();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic w(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdat <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic r(input logic [7:0] a);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 q = rdat;
   endtask
   task automatic mv(input int n, input logic d);
      @(posedge clk iff tick);
      dir <= d;
      repeat (n) begin
         step <= 1'b1;
         @(posedge clk);
      end
      step <= 1'b0;
      repeat (20) @(posedge clk);
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      for (int i = 0; i < 7; i++) begin
         r(ra[i]);
         chk(q, {16'h0, rv[i]});
      end
      $display("reset values done");
      w(ADDR_TRIM, 32'h0100);
      w(ADDR_CTRL, 32'h1);
      repeat (20) @(posedge clk);
      r(ADDR_ANGLE);
      chk(q, {16'h0, ANG_M30 + 16'h0100});
      $display("start angle done");
      repeat (6) mv(1, 1'b1);
      r(ADDR_TALLY_LOW);
      chk(q, 32'h6);
      repeat (8) mv(1, 1'b0);
      r(ADDR_TALLY_LOW);
      chk(q, 32'hfffe);
      r(ADDR_TALLY_HIGH);
      chk(q, 32'hffff);
      $display("tally done");
      @(posedge clk) bad <= 2'h3;
      repeat (20) @(posedge clk);
      bad <= 2'h2;
      repeat (20) @(posedge clk);
      r(ADDR_FAULT);
      chk(q & 32'h8000, 32'h8000);
      w(ADDR_FAULT, 32'h8000);
      @(posedge clk) bad <= 2'h0;
      mv(1, 1'b1);
      repeat (2) mv(2, 1'b1);
      r(ADDR_FAULT);
      chk(q & 32'h8000, 32'h0);
      mv(2, 1'b1);
      r(ADDR_FAULT);
      chk(q & 32'h8000, 32'h8000);
      $display("pattern faults done");
      w(ADDR_SILENCE, 32'h1);
      repeat (32900) @(posedge clk);
      r(ADDR_FAULT);
      chk(q & 32'h3, 32'h3);
      chk({16'h0, flt & 16'h3}, 32'h3);
      repeat (2) mv(1, 1'b1);
      r(ADDR_FAULT);
      chk(q & 32'h3, 32'h2);
      $display("zero speed done");
      w(ADDR_SELECT, {30'h0, SRC_HYBRID});
      @(posedge clk) spd <= 16'h2000;
      repeat (20) @(posedge clk);
      r(ADDR_STATUS);
      chk(q & 32'h80, 32'h80);
      r(ADDR_ANGLE);
      chk(q, {16'h0, flx});
      chk({16'h0, ang}, {16'h0, flx});
      @(posedge clk) spd <= 16'h0100;
      repeat (20) @(posedge clk);
      r(ADDR_STATUS);
      chk(q & 32'h80, 32'h0);
      r(ADDR_ANGLE);
      chk(q, {16'h0, ANG_0 + 16'h0100});
      $display("hybrid done");
      mv(1, 1'b1);
      w(ADDR_CTRL, 32'h0);
      w(ADDR_CONFIG, {30'h0, MODE_TWO});
      w(ADDR_CTRL, 32'h1);
      repeat (20) @(posedge clk);
      r(ADDR_ANGLE);
      chk(q, {16'h0, ANG_120 + 16'h0100});
      $display("two sensor start done");
      report_and_stop();
   end
endmodule // tb_rotor_sensor_tracker
`default_nettype wire

/* File: rtl/rstk_pkg.sv */
// constants and types for the rotor sensor tracker
package rstk_pkg;
   // ****************
   // register offsets
   // ****************
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_CONFIG = 8'h04;
   localparam logic [7:0] ADDR_TRIM = 8'h08;
   localparam logic [7:0] ADDR_SILENCE = 8'h0c;
   localparam logic [7:0] ADDR_SPAN = 8'h10;
   localparam logic [7:0] ADDR_SELECT = 8'h14;
   localparam logic [7:0] ADDR_UP = 8'h18;
   localparam logic [7:0] ADDR_DOWN = 8'h1c;
   localparam logic [7:0] ADDR_FAULT = 8'h20;
   localparam logic [7:0] ADDR_TALLY_LOW = 8'h24;
   localparam logic [7:0] ADDR_TALLY_HIGH = 8'h28;
   localparam logic [7:0] ADDR_ANGLE = 8'h2c;
   localparam logic [7:0] ADDR_STATUS = 8'h30;
   // ****************
   // fields and reset values
   // ****************
   localparam int CFG_ARCTAN_BIT = 5;
   localparam int FAULT_ZERO_BIT = 0;
   localparam int FAULT_TIMEOUT_BIT = 1;
   localparam int FAULT_INVALID_BIT = 15;
   localparam logic [15:0] RESET_CONFIG = 16'h0000;
   localparam logic [15:0] RESET_TRIM = 16'h0000;
   localparam logic [15:0] RESET_SILENCE = 16'h000a;
   localparam logic [15:0] RESET_SPAN = 16'h0006;
   localparam logic [15:0] RESET_UP = 16'h1000;
   localparam logic [15:0] RESET_DOWN = 16'h0c00;
   // sensor modes in config bits 1:0
   localparam logic [1:0] MODE_THREE = 2'h0;
   localparam logic [1:0] MODE_TWO = 2'h1;
   localparam logic [1:0] MODE_ANALOG = 2'h2;
   // angle sources
   localparam logic [1:0] SRC_SENSOR = 2'h0;
   localparam logic [1:0] SRC_FLUX = 2'h1;
   localparam logic [1:0] SRC_HYBRID = 2'h2;
   // ****************
   // timing
   // ****************
   localparam int CLK_HZ = 25000000;
   localparam int SILENCE_UNIT_MS = 16;
   localparam int SILENCE_UNIT_CYCLES = SILENCE_UNIT_MS * (CLK_HZ / 1000);
   localparam logic [12:0] ZERO_FREQ_PERIODS = 13'h1000;
   localparam logic [12:0] INTERVAL_MAX = 13'h1fff;
   // ****************
   // angle scale: 65536 counts per turn
   // ****************
   localparam logic [15:0] ANG_M60 = 16'hd555;
   localparam logic [15:0] ANG_M30 = 16'heaab;
   localparam logic [15:0] ANG_0 = 16'h0000;
   localparam logic [15:0] ANG_30 = 16'h1555;
   localparam logic [15:0] ANG_60 = 16'h2aab;
   localparam logic [15:0] ANG_90 = 16'h4000;
   localparam logic [15:0] ANG_120 = 16'h5555;
   localparam logic [15:0] ANG_150 = 16'h6aab;
   localparam logic [15:0] ANG_180 = 16'h8000;
   localparam logic [15:0] ANG_210 = 16'h9555;
   localparam logic [15:0] ANG_240 = 16'haaab;
   localparam logic [15:0] ANG_270 = 16'hc000;
   localparam logic [15:0] INV_SQRT3_Q15 = 16'h49e7;
   localparam int CORDIC_STEPS = 14;
   localparam logic [15:0] ATAN_TABLE [0:13] = '{16'h2000, 16'h12e4, 16'h09fb, 16'h0511,
      16'h028b, 16'h0146, 16'h00a3, 16'h0051, 16'h0029, 16'h0014, 16'h000a, 16'h0005,
      16'h0003, 16'h0001};
   typedef enum logic [1:0] {
      RSTK_IDLE = 2'b00,
      RSTK_TURN = 2'b01,
      RSTK_DONE = 2'b11
   } rstk_cordic_t;
endpackage

/* File: rtl/rstk_tracker.sv */
// rotor sensor tracker: fault checks, pattern validation, tally, angle output
//
// Implementation choices: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module rstk_tracker
   import rstk_pkg::*;
#(
   parameter int SILENCE_UNIT = SILENCE_UNIT_CYCLES
) (
   input wire logic core_clk_in,
   input wire logic rstn_in,
   input wire logic [7:0] addr_in,
   input wire logic [31:0] wr_data_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [31:0] rd_data_out,
   input wire logic pwm_tick_in,
   input wire logic sensor_input_a_in,
   input wire logic sensor_input_b_in,
   input wire logic sensor_input_c_in,
   input wire logic [11:0] analog_pair1_pos_in,
   input wire logic [11:0] analog_pair1_neg_in,
   input wire logic [11:0] analog_pair2_pos_in,
   input wire logic [11:0] analog_pair2_neg_in,
   input wire logic [15:0] flux_angle_in,
   input wire logic [15:0] motor_speed_in,
   output logic [15:0] rotor_angle_out,
   output logic [15:0] fault_word_out
);
   // ****************
   // lookup functions
   // ****************
   // sector of a pattern, 7 when not part of the mode's sequence
   function automatic logic [2:0] sector_of(input logic [1:0] mode, input logic [2:0] p);
      logic [2:0] s;
      s = 3'h7;
      if (mode == MODE_TWO) begin
         case (p)
            3'h3: s = 3'h1;
            3'h2: s = 3'h2;
            3'h0: s = 3'h4;
            3'h1: s = 3'h5;
            default: s = 3'h7;
         endcase
      end else begin
         case (p)
            3'h1: s = 3'h0;
            3'h3: s = 3'h1;
            3'h2: s = 3'h2;
            3'h6: s = 3'h3;
            3'h4: s = 3'h4;
            3'h5: s = 3'h5;
            default: s = 3'h7;
         endcase
      end
      return s;
   endfunction

   // pattern expected next in one direction
   function automatic logic [2:0] next_of(input logic [1:0] mode, input logic [2:0] p,
                                          input logic cw);
      logic [2:0] n;
      n = p;
      if (mode == MODE_TWO) begin
         case (p)
            3'h3: n = cw ? 3'h2 : 3'h1;
            3'h2: n = cw ? 3'h0 : 3'h3;
            3'h0: n = cw ? 3'h1 : 3'h2;
            default: n = cw ? 3'h3 : 3'h0;
         endcase
      end else begin
         case (p)
            3'h1: n = cw ? 3'h3 : 3'h5;
            3'h3: n = cw ? 3'h2 : 3'h1;
            3'h2: n = cw ? 3'h6 : 3'h3;
            3'h6: n = cw ? 3'h4 : 3'h2;
            3'h4: n = cw ? 3'h5 : 3'h6;
            default: n = cw ? 3'h1 : 3'h4;
         endcase
      end
      return n;
   endfunction

   // start edge angle of a sector
   function automatic logic [15:0] edge_of(input logic [2:0] s);
      logic [15:0] a;
      case (s)
         3'h0: a = ANG_M60;
         3'h1: a = ANG_0;
         3'h2: a = ANG_60;
         3'h3: a = ANG_120;
         3'h4: a = ANG_180;
         default: a = ANG_240;
      endcase
      return a;
   endfunction

   // wide sectors only exist with two sensors
   function automatic logic wide_of(input logic [1:0] mode, input logic [2:0] s);
      return (mode == MODE_TWO) && ((s == 3'h2) || (s == 3'h5));
   endfunction

   // ****************
   // register file
   // ****************
   logic run;
   logic [15:0] config_reg;
   logic [15:0] angle_trim;
   logic [15:0] sensor_silence_limit;
   logic [15:0] arctan_sector_span;
   logic [1:0] angle_source_select;
   logic [15:0] up_switch_speed;
   logic [15:0] down_switch_speed;
   logic [15:0] fault_word;
   logic [31:0] tally;
   logic [2:0] pattern;
   logic [2:0] sector;
   logic using_flux;
   logic [1:0] mode;
   logic fault_clear_zero;

   assign mode = config_reg[1:0];
   assign fault_clear_zero = 1'b0;

   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         run <= 1'b0;
         config_reg <= RESET_CONFIG;
         angle_trim <= RESET_TRIM;
         sensor_silence_limit <= RESET_SILENCE;
         arctan_sector_span <= RESET_SPAN;
         angle_source_select <= SRC_SENSOR;
         up_switch_speed <= RESET_UP;
         down_switch_speed <= RESET_DOWN;
      end else if (wr_in) begin
         if (addr_in == ADDR_CTRL) begin
            run <= wr_data_in[0];
         end else if (addr_in == ADDR_CONFIG) begin
            config_reg <= wr_data_in[15:0];
         end else if (addr_in == ADDR_TRIM) begin
            angle_trim <= wr_data_in[15:0];
         end else if (addr_in == ADDR_SILENCE) begin
            sensor_silence_limit <= wr_data_in[15:0];
         end else if (addr_in == ADDR_SPAN) begin
            arctan_sector_span <= wr_data_in[15:0];
         end else if (addr_in == ADDR_SELECT) begin
            angle_source_select <= wr_data_in[1:0];
         end else if (addr_in == ADDR_UP) begin
            up_switch_speed <= wr_data_in[15:0];
         end else if (addr_in == ADDR_DOWN) begin
            down_switch_speed <= wr_data_in[15:0];
         end
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         rd_data_out <= 32'h0000_0000;
      end else if (rd_in) begin
         if (addr_in == ADDR_CTRL) begin
            rd_data_out <= {31'h0, run};
         end else if (addr_in == ADDR_CONFIG) begin
            rd_data_out <= {16'h0, config_reg};
         end else if (addr_in == ADDR_TRIM) begin
            rd_data_out <= {16'h0, angle_trim};
         end else if (addr_in == ADDR_SILENCE) begin
            rd_data_out <= {16'h0, sensor_silence_limit};
         end else if (addr_in == ADDR_SPAN) begin
            rd_data_out <= {16'h0, arctan_sector_span};
         end else if (addr_in == ADDR_SELECT) begin
            rd_data_out <= {30'h0, angle_source_select};
         end else if (addr_in == ADDR_UP) begin
            rd_data_out <= {16'h0, up_switch_speed};
         end else if (addr_in == ADDR_DOWN) begin
            rd_data_out <= {16'h0, down_switch_speed};
         end else if (addr_in == ADDR_FAULT) begin
            rd_data_out <= {16'h0, fault_word};
         end else if (addr_in == ADDR_TALLY_LOW) begin
            rd_data_out <= {16'h0, tally[15:0]};
         end else if (addr_in == ADDR_TALLY_HIGH) begin
            rd_data_out <= {16'h0, tally[31:16]};
         end else if (addr_in == ADDR_ANGLE) begin
            rd_data_out <= {16'h0, rotor_angle_out};
         end else if (addr_in == ADDR_STATUS) begin
            rd_data_out <= {24'h0, using_flux, sector, 1'b0, pattern};
         end else begin
            rd_data_out <= 32'h0000_0000;
         end
      end else begin
         rd_data_out <= 32'h0000_0000;
      end
   end

   // ****************
   // transition capture
   // ****************
   logic [2:0] raw_pattern;
   logic [2:0] seen_pattern;
   logic [2:0] latched_pattern;
   logic pending;
   logic take_event;

   assign raw_pattern = {sensor_input_c_in, sensor_input_b_in, sensor_input_a_in};
   assign take_event = pwm_tick_in && pending;

   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         seen_pattern <= raw_pattern; // no false event after reset
         latched_pattern <= raw_pattern;
         pending <= 1'b0;
      end else begin
         seen_pattern <= raw_pattern;
         if (raw_pattern != seen_pattern) begin
            latched_pattern <= raw_pattern;
            pending <= 1'b1;
         end else if (take_event) begin
            pending <= 1'b0;
         end
      end
   end

   // ****************
   // zero-speed and timeout checks
   // ****************
   logic [12:0] interval;
   logic zero_freq;
   logic [18:0] unit_count;
   logic [15:0] unit_tally;
   logic timeout_hit;

   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         interval <= 13'h0;
         zero_freq <= 1'b0;
      end else if (!run) begin
         interval <= 13'h0;
         zero_freq <= 1'b0;
      end else if (take_event) begin
         interval <= 13'h0;
         zero_freq <= (interval > ZERO_FREQ_PERIODS);
      end else if (pwm_tick_in) begin
         if (interval != INTERVAL_MAX) begin
            interval <= interval + 13'h1;
         end
         if (interval > ZERO_FREQ_PERIODS) begin
            zero_freq <= 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!rstn_in || !zero_freq) begin
         unit_count <= 19'h0;
         unit_tally <= 16'h0;
      end else if (unit_count == 19'(SILENCE_UNIT - 1)) begin
         unit_count <= 19'h0;
         if (unit_tally != 16'hffff) begin
            unit_tally <= unit_tally + 16'h1;
         end
      end else begin
         unit_count <= unit_count + 19'h1;
      end
   end

   assign timeout_hit = zero_freq && (unit_tally >= sensor_silence_limit);

   // ****************
   // pattern validation and tally
   // ****************
   logic [1:0] invalid_run;
   logic [1:0] unexpected_run;
   logic is_invalid;
   logic match_cw;
   logic match_ccw;
   logic [2:0] new_sector;
   logic [15:0] est_angle;
   logic [15:0] moves;
   logic run_d;
   logic invalid_confirm;

   assign is_invalid = (mode == MODE_THREE) && ((latched_pattern == 3'h7) ||
                       (latched_pattern == 3'h0));
   assign match_cw = latched_pattern == next_of(mode, pattern, 1'b1);
   assign match_ccw = latched_pattern == next_of(mode, pattern, 1'b0);
   assign new_sector = sector_of(mode, latched_pattern);
   assign invalid_confirm = take_event && ((is_invalid && invalid_run == 2'h1) ||
      (!is_invalid && !match_cw && !match_ccw && unexpected_run == 2'h2));

   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         run_d <= 1'b0;
         pattern <= 3'h0;
         sector <= 3'h0;
         est_angle <= ANG_0;
         tally <= 32'h0;
         moves <= 16'h0;
         invalid_run <= 2'h0;
         unexpected_run <= 2'h0;
      end else begin
         run_d <= run;
         if (run && !run_d) begin
            pattern <= raw_pattern;
            sector <= sector_of(mode, raw_pattern);
            moves <= 16'h0;
            invalid_run <= 2'h0;
            unexpected_run <= 2'h0;
            if (mode == MODE_TWO) begin
               case (raw_pattern)
                  3'h1: est_angle <= ANG_M60;
                  3'h3: est_angle <= ANG_30;
                  3'h2: est_angle <= ANG_120;
                  default: est_angle <= ANG_210;
               endcase
            end else begin
               case (raw_pattern)
                  3'h1: est_angle <= ANG_M30;
                  3'h3: est_angle <= ANG_30;
                  3'h2: est_angle <= ANG_90;
                  3'h6: est_angle <= ANG_150;
                  3'h4: est_angle <= ANG_210;
                  default: est_angle <= ANG_270;
               endcase
            end
         end else if (take_event) begin
            if (is_invalid) begin
               invalid_run <= (invalid_run == 2'h1) ? 2'h0 : invalid_run + 2'h1;
               unexpected_run <= 2'h0;
            end else if (!match_cw && !match_ccw) begin
               unexpected_run <= (unexpected_run == 2'h2) ? 2'h0 : unexpected_run + 2'h1;
               invalid_run <= 2'h0;
            end else begin
               invalid_run <= 2'h0;
               unexpected_run <= 2'h0;
               pattern <= latched_pattern;
               sector <= new_sector;
               if (moves != 16'hffff) begin
                  moves <= moves + 16'h1;
               end
               if (match_cw) begin
                  est_angle <= edge_of(new_sector);
                  tally <= tally + (wide_of(mode, sector) ? 32'h2 : 32'h1);
               end else begin
                  est_angle <= edge_of(sector);
                  tally <= tally - (wide_of(mode, new_sector) ? 32'h2 : 32'h1);
               end
            end
         end
      end
   end

   // sticky timeout and invalid bits, set wins over a write-one clear; zero bit follows zero_freq
   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         fault_word <= 16'h0000;
      end else begin
         fault_word[FAULT_ZERO_BIT] <= zero_freq;
         if (timeout_hit) begin
            fault_word[FAULT_TIMEOUT_BIT] <= 1'b1;
         end else if (wr_in && addr_in == ADDR_FAULT && wr_data_in[FAULT_TIMEOUT_BIT]) begin
            fault_word[FAULT_TIMEOUT_BIT] <= 1'b0;
         end
         if (invalid_confirm) begin
            fault_word[FAULT_INVALID_BIT] <= 1'b1;
         end else if (wr_in && addr_in == ADDR_FAULT && wr_data_in[FAULT_INVALID_BIT]) begin
            fault_word[FAULT_INVALID_BIT] <= 1'b0;
         end
      end
   end

   // ****************
   // differential, clarke and arctangent
   // ****************
   logic signed [12:0] diff_u;
   logic signed [12:0] diff_v;
   logic signed [31:0] beta_product;
   rstk_cordic_t cordic_state;
   logic signed [17:0] cx;
   logic signed [17:0] cy;
   logic [15:0] cz;
   logic [3:0] step;
   logic [15:0] arctan_angle;

   assign beta_product = (32'(diff_u) + 32'(diff_v) + 32'(diff_v)) *
                         $signed({16'h0, INV_SQRT3_Q15});

   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         diff_u <= 13'sh0;
         diff_v <= 13'sh0;
      end else if (pwm_tick_in) begin
         diff_u <= $signed({1'b0, analog_pair1_pos_in}) - $signed({1'b0, analog_pair1_neg_in});
         diff_v <= $signed({1'b0, analog_pair2_pos_in}) - $signed({1'b0, analog_pair2_neg_in});
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         cordic_state <= RSTK_IDLE;
         cx <= 18'sh0;
         cy <= 18'sh0;
         cz <= 16'h0;
         step <= 4'h0;
         arctan_angle <= 16'h0;
      end else begin
         case (cordic_state)
            RSTK_IDLE: begin
               if (pwm_tick_in) begin
                  cordic_state <= RSTK_TURN;
                  step <= 4'h0;
                  if (diff_u < 0) begin
                     cx <= -18'(diff_u);
                     cy <= -18'(beta_product >>> 15);
                     cz <= ANG_180;
                  end else begin
                     cx <= 18'(diff_u);
                     cy <= 18'(beta_product >>> 15);
                     cz <= ANG_0;
                  end
               end
            end
            RSTK_TURN: begin
               if (cy > 0) begin
                  cx <= cx + (cy >>> step);
                  cy <= cy - (cx >>> step);
                  cz <= cz + ATAN_TABLE[step];
               end else begin
                  cx <= cx - (cy >>> step);
                  cy <= cy + (cx >>> step);
                  cz <= cz - ATAN_TABLE[step];
               end
               step <= step + 4'h1;
               if (step == 4'(CORDIC_STEPS - 1)) begin
                  cordic_state <= RSTK_DONE;
               end
            end
            RSTK_DONE: begin
               arctan_angle <= cz + angle_trim;
               cordic_state <= RSTK_IDLE;
            end
            default: cordic_state <= RSTK_IDLE;
         endcase
      end
   end

   // ****************
   // angle source selection
   // ****************
   logic arctan_active;

   assign arctan_active = config_reg[CFG_ARCTAN_BIT] && (mode == MODE_ANALOG) &&
                          (moves < arctan_sector_span);

   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         using_flux <= 1'b0;
      end else if (angle_source_select != SRC_HYBRID) begin
         using_flux <= 1'b0;
      end else if (pwm_tick_in) begin
         if (!using_flux && motor_speed_in > up_switch_speed) begin
            using_flux <= 1'b1;
         end else if (using_flux && motor_speed_in < down_switch_speed) begin
            using_flux <= 1'b0;
         end
      end
   end

   // sensor and flux paths both run; only the output is switched
   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         rotor_angle_out <= 16'h0;
      end else if (pwm_tick_in) begin
         if (angle_source_select == SRC_FLUX || using_flux) begin
            rotor_angle_out <= flux_angle_in;
         end else if (arctan_active) begin
            rotor_angle_out <= arctan_angle;
         end else begin
            rotor_angle_out <= est_angle + angle_trim;
         end
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         fault_word_out <= 16'h0;
      end else begin
         fault_word_out <= fault_word;
      end
   end
endmodule // rstk_tracker
`default_nettype wire
